//--- include/rwx_cfg.svh
`ifndef RWX_CFG_SVH
`define RWX_CFG_SVH
// ==================================================
// Register offsets (byte addresses, one word each)
`define RWX_OFF_R0    8'h00
`define RWX_OFF_R1    8'h04
`define RWX_OFF_R2    8'h08
`define RWX_OFF_R3    8'h0c
`define RWX_OFF_R4    8'h10
`define RWX_OFF_R5    8'h14
`define RWX_OFF_R6    8'h18
`define RWX_OFF_R7    8'h1c
`define RWX_OFF_STAT  8'h20
`define RWX_OFF_NINT  8'h24
`define RWX_OFF_NFRAC 8'h28
`define RWX_IDX_LAST  4'ha
// ==================================================
// Field positions
`define RWX_START_B   31
`define RWX_MUX_HI    30
`define RWX_MUX_LO    27
`define RWX_INT_HI    26
`define RWX_INT_LO    15
`define RWX_FMSB_HI   14
`define RWX_FMSB_LO   3
`define RWX_FLSB_HI   27
`define RWX_FLSB_LO   15
`define RWX_W12_HI    14
`define RWX_W12_LO    3
`define RWX_RTYPE_HI  11
`define RWX_RTYPE_LO  10
`define RWX_CRST_B    3
`define RWX_DIVSEL_B  6
`define RWX_SECONDARY_TICK_DIVIDER_HI   18
`define RWX_SECONDARY_TICK_DIVIDER_LO   7
`define RWX_DMODE_HI  20
`define RWX_DMODE_LO  19
`define RWX_MCTL_HI   25
`define RWX_MCTL_LO   21
`define RWX_HOP_HI    18
`define RWX_HOP_LO    3
`define RWX_SHF_HI    22
`define RWX_SHF_LO    19
`define RWX_BANK_B    23
`define RWX_IMODE_HI  27
`define RWX_IMODE_LO  26
`define RWX_PARAB_B   28
`define RWX_EXTSTP_B  29
`define RWX_STEPS_HI  22
`define RWX_STEPS_LO  3
`define RWX_DSTART_B  15
`define RWX_DCLK_B    16
`define RWX_GAP_B     17
`define RWX_DFL_B     18
`define RWX_FAST_B    19
// ==================================================
// Codes and reset values
`define RWX_MUX_FN    4'hf
`define RWX_MC_DONE   5'h03
`define RWX_MC_IRQ    5'h02
`define RWX_DM_FLOCK  2'h1
`define RWX_IM_OFF    2'h0
`define RWX_IM_STOP   2'h3
`define RWX_RB_BITS   37
`define RWX_RST_WORD  32'h0000_0000
`endif

//--- include/rwx_pkg.sv
package rwx_pkg;
  // ==================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SDLY = 3'b001,
    ST_RUN  = 3'b010,
    ST_GAP  = 3'b011,
    ST_DONE = 3'b100
  } rwx_state_t;
  // Ramp shapes in the two-bit type field
  typedef enum logic [1:0] {
    RT_SAW   = 2'b00,
    RT_TRI   = 2'b01,
    RT_SAW1  = 2'b10,
    RT_BURST = 2'b11
  } rwx_rtype_t;
endpackage

//--- src/rwx_tick_timer.sv
`timescale 1ns/1ps
// Down-counter: word units of unit cycles each
module rwx_tick_timer #(
  parameter int W = 12
) (
  input  wire logic         pclk,       // Clock
  input  wire logic         presetn,    // Async reset
  input  wire logic         load,       // Start a new count
  input  wire logic [W-1:0] word,       // Number of units
  input  wire logic [W-1:0] unit,       // Cycles per unit
  output logic              busy,       // Counting
  output logic              first_unit, // Inside first unit
  output logic              done        // One-cycle end pulse
);
  logic [W-1:0] wcnt_r;
  logic [W-1:0] ucnt_r;
  logic         busy_r;
  logic         first_r;
  logic         done_r;
  // ==================================================
  // Counting
  // Zero word or unit counts as one, so a load never hangs
  wire unit_end = busy_r && (ucnt_r <= W'(1));
  wire last     = unit_end && (wcnt_r <= W'(1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wcnt_r  <= '0;
      ucnt_r  <= '0;
      busy_r  <= 1'b0;
      first_r <= 1'b0;
      done_r  <= 1'b0;
    end
    else
    begin
      done_r <= last && !load;
      if (load)
      begin
        wcnt_r  <= word;
        ucnt_r  <= unit;
        busy_r  <= 1'b1;
        first_r <= 1'b1;
      end
      else if (unit_end)
      begin
        ucnt_r  <= unit;
        wcnt_r  <= wcnt_r - W'(1);
        first_r <= 1'b0;
        busy_r  <= !last;
      end
      else if (busy_r)
        ucnt_r <= ucnt_r - W'(1);
    end
  end

  assign busy       = busy_r;
  assign first_unit = first_r;
  assign done       = done_r;
endmodule

//--- src/rwx_rb_shift.sv
`timescale 1ns/1ps
// Readback shifter, MSB first
module rwx_rb_shift #(
  parameter int N = 37
) (
  input  wire logic         pclk,    // Clock
  input  wire logic         presetn, // Async reset
  input  wire logic         load,    // Capture word
  input  wire logic [N-1:0] din,     // Word to send
  input  wire logic         shift,   // Advance one bit
  output logic              dout     // Current bit
);
  logic [N-1:0] sr_r;
  // ==================================================
  // Load wins over shift so a new capture is never torn
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sr_r <= '0;
    else if (load)
      sr_r <= din;
    else if (shift)
      sr_r <= {sr_r[N-2:0], 1'b0};
  end

  assign dout = sr_r[N-1];
endmodule

//--- src/rwx_top.sv
`timescale 1ns/1ps
`include "rwx_cfg.svh"
// Notes on behaviour
// - delayed start holds off ramp start
// - delay equals PFD period times word
// - clock select multiplies delay by divider
// - gap delay between sawtooth/triangle bursts
// - fast lock in first gap period
// - parabolic steps grow by step index
// - fast ramp uses separate down-slope bank
// - ramp start bit begins stepping
// - ramp-complete pulse on status pin
// - trigger pin steps ramp, timer bypassed
// - trigger rising edge raises interrupt
// - mode 00 off, 01 continue, 11 stop
// - readback only while ramp active
// - capture 37-bit word, shift out
// - bits change on serial clock rise
// - R0 write opens fast-lock window
// - R0 write opens no fast-lock window during ramp mode
// - each tick before the end tick adds shifted hop word, subtracts it on a triangle down slope
module rwx_top #(
  parameter int AW = 8
) (
  input  wire logic          pclk,              // PFD-rate clock
  input  wire logic          presetn,           // Async reset
  input  wire logic          psel,              // APB select
  input  wire logic          penable,           // APB enable
  input  wire logic          pwrite,            // APB direction
  input  wire logic [AW-1:0] paddr,             // APB address
  input  wire logic [31:0]   pwdata,            // APB write data
  output logic [31:0]        prdata,            // APB read data
  output logic               pready,            // APB ready
  output logic               pslverr,           // APB error
  input  wire logic          step_trigger,      // External step pin
  input  wire logic          readback_clk,      // Host serial clock
  output logic               status_output_pin, // Status pin
  output logic               fast_lock_out,     // Wide bandwidth
  output logic               ramp_active,       // Ramp running
  output logic [11:0]        n_int_out,         // Divider integer
  output logic [24:0]        n_frac_out         // Divider fraction
);
  // ==================================================
  // Register file
  logic [31:0] cfg_r [0:7];
  logic [11:0] ramp_tick_divider_b [0:1];
  logic [15:0] hop_b [0:1];
  logic [3:0]  shf_b [0:1];
  logic [19:0] stp_b [0:1];
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  function automatic logic hit(input logic en, input logic [3:0] a,
                               input logic [3:0] i);
    return en && (a == i);
  endfunction

  // Access phase completes on the cycle pready is high
  wire       setup  = psel && !penable;
  wire       acc    = psel && penable && pready_r;
  wire       wr_acc = acc && pwrite;
  wire [3:0] widx   = paddr[5:2];
  wire       mapped = (paddr[1:0] == 2'b00) && (paddr[AW-1:6] == '0) &&
                      (widx <= `RWX_IDX_LAST);
  wire       r0_wr  = hit(wr_acc && mapped, widx, 4'h0);

  // Plain words hold every field; R0 to R7 writable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < 8; i++)
        cfg_r[i] <= `RWX_RST_WORD;
    else if (wr_acc && mapped && !widx[3])
      cfg_r[widx[2:0]] <= pwdata;
  end

  // Banked slope settings; R5/R6 bank picked by the write's own bit 23, R2 bank by the R4 select bit
  genvar b;
  generate
    for (b = 0; b < 2; b++)
    begin : g_bank
      wire w2 = hit(wr_acc && mapped, widx, 4'h2) &&
                (cfg_r[4][`RWX_DIVSEL_B] == 1'(b));
      wire w5 = hit(wr_acc && mapped, widx, 4'h5) &&
                (pwdata[`RWX_BANK_B] == 1'(b));
      wire w6 = hit(wr_acc && mapped, widx, 4'h6) &&
                (pwdata[`RWX_BANK_B] == 1'(b));
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ramp_tick_divider_b[b] <= '0;
          hop_b[b]  <= '0;
          shf_b[b]  <= '0;
          stp_b[b]  <= '0;
        end
        else
        begin
          if (w2)
            ramp_tick_divider_b[b] <= pwdata[`RWX_W12_HI:`RWX_W12_LO];
          if (w5)
            hop_b[b] <= pwdata[`RWX_HOP_HI:`RWX_HOP_LO];
          if (w5)
            shf_b[b] <= pwdata[`RWX_SHF_HI:`RWX_SHF_LO];
          if (w6)
            stp_b[b] <= pwdata[`RWX_STEPS_HI:`RWX_STEPS_LO];
        end
      end
    end
  endgenerate

  // ==================================================
  // Decoded controls
  wire [3:0]  mux_sel  = cfg_r[0][`RWX_MUX_HI:`RWX_MUX_LO];
  wire [36:0] n_base   = {cfg_r[0][`RWX_INT_HI:`RWX_INT_LO],
                          cfg_r[0][`RWX_FMSB_HI:`RWX_FMSB_LO],
                          cfg_r[1][`RWX_FLSB_HI:`RWX_FLSB_LO]};
  wire [1:0]  rtype    = cfg_r[3][`RWX_RTYPE_HI:`RWX_RTYPE_LO];
  wire        cnt_rst  = cfg_r[3][`RWX_CRST_B];
  wire [11:0] secondary_tick_divider     = cfg_r[4][`RWX_SECONDARY_TICK_DIVIDER_HI:`RWX_SECONDARY_TICK_DIVIDER_LO];
  wire [1:0]  dmode    = cfg_r[4][`RWX_DMODE_HI:`RWX_DMODE_LO];
  wire [4:0]  mctl     = cfg_r[4][`RWX_MCTL_HI:`RWX_MCTL_LO];
  wire [1:0]  imode    = cfg_r[5][`RWX_IMODE_HI:`RWX_IMODE_LO];
  wire        parab    = cfg_r[5][`RWX_PARAB_B];
  wire        ext_en   = cfg_r[5][`RWX_EXTSTP_B];
  wire [11:0] dly_word = cfg_r[7][`RWX_W12_HI:`RWX_W12_LO];
  wire        dstart   = cfg_r[7][`RWX_DSTART_B];
  wire        dclk_sel = cfg_r[7][`RWX_DCLK_B];
  wire        gap_en   = cfg_r[7][`RWX_GAP_B];
  wire        dfl_en   = cfg_r[7][`RWX_DFL_B];
  wire        fast_en  = cfg_r[7][`RWX_FAST_B];
  wire        mux_done = (mux_sel == `RWX_MUX_FN) && (mctl == `RWX_MC_DONE);
  wire        mux_irq  = (mux_sel == `RWX_MUX_FN) && (mctl == `RWX_MC_IRQ);

  // ==================================================
  // Sequencer state
  rwx_pkg::rwx_state_t st_r, st_nxt;
  logic [36:0] n_r, n_nxt;
  logic [36:0] inc_r, inc_nxt;
  logic [19:0] idx_r, idx_nxt;
  logic        dir_r, dir_nxt;
  logic        done_r, done_nxt;
  logic        go_r, stop_r, halt_r;
  logic        trig_q_r, sclk_q_r, fl_r, pin_r;
  logic        dly_ld, tmr_ld;
  logic        dly_done, dly_first, tmr_done, fl_busy, rb_bit;
  logic        step_v;
  logic [36:0] stp_amt;

  // Down slope of a fast triangle reads bank 1
  wire        bk      = fast_en && (rtype == rwx_pkg::RT_TRI) && dir_r;
  wire [19:0] steps   = stp_b[bk];
  wire [36:0] hop     = 37'($signed(hop_b[bk])) << shf_b[bk];
  wire        active  = (st_r != rwx_pkg::ST_IDLE);
  // Pins are synchronous, so one flop is enough for edges
  wire        trig_rise = step_trigger && !trig_q_r;
  wire        sclk_rise = readback_clk && !sclk_q_r;
  wire        tick    = (ext_en ? trig_rise : tmr_done) && !halt_r;
  wire        gap_ok  = gap_en && ((rtype == rwx_pkg::RT_SAW) ||
                                   (rtype == rwx_pkg::RT_TRI));
  wire [11:0] dly_unit = dclk_sel ? ramp_tick_divider_b[0] : 12'h001;
  wire        irq_hit = trig_rise && mux_irq && (imode != `RWX_IM_OFF)
                        && active;
  wire        fl_ld   = r0_wr && (dmode == `RWX_DM_FLOCK) && !active &&
                        !pwdata[`RWX_START_B];

  // Step amount; parabola accumulates one hop per step
  always_comb
  begin
    stp_amt = parab ? inc_r + hop : hop;
  end

  // Next-state logic
  always_comb
  begin
    st_nxt   = st_r;
    n_nxt    = n_r;
    idx_nxt  = idx_r;
    inc_nxt  = inc_r;
    dir_nxt  = dir_r;
    done_nxt = 1'b0;
    dly_ld   = 1'b0;
    tmr_ld   = 1'b0;
    step_v   = st_r == rwx_pkg::ST_RUN && tick;
    if (stop_r)
      st_nxt = rwx_pkg::ST_IDLE;
    else if (go_r)
    begin
      n_nxt   = n_base;
      idx_nxt = '0;
      inc_nxt = '0;
      dir_nxt = 1'b0;
      if (dstart)
      begin
        st_nxt = rwx_pkg::ST_SDLY;
        dly_ld = 1'b1;
      end
      else
      begin
        st_nxt = rwx_pkg::ST_RUN;
        tmr_ld = !ext_en;
      end
    end
    else
      case (st_r)
        rwx_pkg::ST_IDLE:
          n_nxt = n_base;
        rwx_pkg::ST_SDLY:
          if (dly_done)
          begin
            st_nxt = rwx_pkg::ST_RUN;
            tmr_ld = !ext_en;
          end
        rwx_pkg::ST_RUN:
          if (step_v)
          begin
            tmr_ld = !ext_en;
            if (idx_r != steps)
            begin
              n_nxt    = dir_r ? n_r - stp_amt : n_r + stp_amt;
              inc_nxt  = parab ? stp_amt : inc_r;
              idx_nxt  = idx_r + 20'h00001;
              done_nxt = (idx_r + 20'h00001) == steps;
              if (done_nxt && rtype == rwx_pkg::RT_BURST)
                st_nxt = rwx_pkg::ST_DONE;
            end
            else
            begin
              // End tick: turn round or return to base
              idx_nxt = '0;
              inc_nxt = '0;
              if (rtype == rwx_pkg::RT_TRI)
                dir_nxt = !dir_r;
              else
                n_nxt = n_base;
              if (rtype == rwx_pkg::RT_SAW1 || rtype == rwx_pkg::RT_BURST)
                st_nxt = rwx_pkg::ST_DONE;
              else if (gap_ok)
              begin
                st_nxt = rwx_pkg::ST_GAP;
                dly_ld = 1'b1;
                tmr_ld = 1'b0;
              end
            end
          end
        rwx_pkg::ST_GAP:
          if (dly_done)
          begin
            st_nxt = rwx_pkg::ST_RUN;
            tmr_ld = !ext_en;
          end
        rwx_pkg::ST_DONE:
          st_nxt = rwx_pkg::ST_DONE;
        default:
          st_nxt = rwx_pkg::ST_IDLE;
      endcase
    // Held counter reset restarts the step counters
    if (cnt_rst && !stop_r)
    begin
      idx_nxt = '0;
      inc_nxt = '0;
    end
  end

  // ==================================================
  // Sequencer and pin registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r   <= rwx_pkg::ST_IDLE;
      n_r    <= '0;
      inc_r  <= '0;
      idx_r  <= '0;
      dir_r  <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      n_r    <= n_nxt;
      inc_r  <= inc_nxt;
      idx_r  <= idx_nxt;
      dir_r  <= dir_nxt;
      done_r <= done_nxt;
    end
  end

  // Start/stop taken one cycle after the write so R0 fields settle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      go_r     <= 1'b0;
      stop_r   <= 1'b0;
      halt_r   <= 1'b0;
      trig_q_r <= 1'b0;
      sclk_q_r <= 1'b0;
      fl_r     <= 1'b0;
      pin_r    <= 1'b0;
    end
    else
    begin
      go_r     <= r0_wr && pwdata[`RWX_START_B];
      stop_r   <= r0_wr && !pwdata[`RWX_START_B];
      trig_q_r <= step_trigger;
      sclk_q_r <= readback_clk;
      if (irq_hit && imode == `RWX_IM_STOP)
        halt_r <= 1'b1;
      else if (go_r || stop_r)
        halt_r <= 1'b0;
      fl_r  <= fl_busy || (dfl_en && st_r == rwx_pkg::ST_GAP && dly_first);
      pin_r <= mux_done ? done_r : (mux_irq ? rb_bit : 1'b0);
    end
  end

  // ==================================================
  // Timers and readback
  rwx_tick_timer #(.W(12)) u_delay (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (dly_ld),
    .word       (dly_word),
    .unit       (dly_unit),
    .busy       (),
    .first_unit (dly_first),
    .done       (dly_done)
  );

  // Step interval is ramp divider times secondary divider
  rwx_tick_timer #(.W(12)) u_step (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (tmr_ld),
    .word       (secondary_tick_divider),
    .unit       (ramp_tick_divider_b[bk]),
    .busy       (),
    .first_unit (),
    .done       (tmr_done)
  );

  rwx_tick_timer #(.W(12)) u_flock (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (fl_ld),
    .word       (secondary_tick_divider),
    .unit       (ramp_tick_divider_b[0]),
    .busy       (fl_busy),
    .first_unit (),
    .done       ()
  );

  rwx_rb_shift #(.N(`RWX_RB_BITS)) u_rb (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (irq_hit),
    .din     (n_r),
    .shift   (sclk_rise),
    .dout    (rb_bit)
  );

  // ==================================================
  // APB answer: zero wait, registered in the setup cycle
  logic [31:0] rd_w;
  always_comb
  begin
    case (widx)
      4'h8:    rd_w = {4'h0, idx_r, 3'h0, fl_r, halt_r, dir_r, done_r,
                       active};
      4'h9:    rd_w = {20'h00000, n_r[36:25]};
      4'ha:    rd_w = {7'h00, n_r[24:0]};
      default: rd_w = widx[3] ? 32'h0000_0000 : cfg_r[widx[2:0]];
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      prdata_r  <= (setup && mapped && !pwrite) ? rd_w : 32'h0000_0000;
    end
  end

  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign status_output_pin = pin_r;
  assign fast_lock_out     = fl_r;
  assign ramp_active       = st_r != rwx_pkg::ST_IDLE ? 1'b1 : 1'b0;
  assign n_int_out         = n_r[36:25];
  assign n_frac_out        = n_r[24:0];
endmodule

//--- tb/rwx_assertions.sv
`timescale 1ns/1ps
// ==================================================
// Port-level checks of the ramp sequencer
module rwx_assertions #(
  parameter int AW = 8
) (
  input wire logic          pclk,              // Clock
  input wire logic          presetn,           // Async reset
  input wire logic          psel,              // APB select
  input wire logic          penable,           // APB enable
  input wire logic          pwrite,            // APB direction
  input wire logic [AW-1:0] paddr,             // APB address
  input wire logic [31:0]   pwdata,            // APB write data
  input wire logic          pready,            // APB ready
  input wire logic          pslverr,           // APB error
  input wire logic          status_output_pin, // Status pin
  input wire logic          fast_lock_out,     // Wide bandwidth
  input wire logic          ramp_active        // Ramp running
);
  logic       wr;
  logic       r0w;
  logic [3:0] mux_r;
  logic [4:0] mc_r;
  logic [1:0] dm_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow pin and lock fields; sampled at the write edge like the design
  assign wr  = psel && penable && pwrite && pready;
  assign r0w = wr && paddr == 8'h00;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mux_r <= 4'h0;
      mc_r  <= 5'h00;
      dm_r  <= 2'h0;
    end
    else
    begin
      if (r0w)
        mux_r <= pwdata[30:27];
      if (wr && paddr == 8'h10)
      begin
        mc_r <= pwdata[25:21];
        dm_r <= pwdata[20:19];
      end
    end
  // ==================================================
  // Properties
  sequence s_start; r0w && pwdata[31]; endsequence
  sequence s_stop; r0w && !pwdata[31]; endsequence
  property p_rdy_setup; psel && !penable |=> pready; endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("no ready after setup");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held too long");
  property p_unmapped; psel && !penable && paddr > 8'h28 |=> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped address accepted");
  property p_start; s_start |-> ##[1:3] ramp_active; endproperty
  a_start: assert property (p_start) else $error("ramp did not start");
  property p_stop; s_stop |-> ##[1:3] !ramp_active; endproperty
  a_stop: assert property (p_stop) else $error("ramp did not stop");
  property p_done; mux_r == 4'hf && mc_r == 5'h03 && status_output_pin |=> !status_output_pin;
  endproperty
  a_done: assert property (p_done) else $error("complete pulse too long");
  property p_flock; s_stop ##0 (dm_r == 2'h1 && !ramp_active) |-> ##[1:3] fast_lock_out;
  endproperty
  a_flock: assert property (p_flock) else $error("no fast lock window");
  property p_no_flock; s_start ##0 !fast_lock_out |=> !fast_lock_out [*3]; endproperty
  a_no_flock: assert property (p_no_flock) else $error("fast lock in ramp");
endmodule
bind rwx_top rwx_assertions #(.AW(AW)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .status_output_pin(status_output_pin), .fast_lock_out(fast_lock_out),
  .ramp_active(ramp_active)
);

//--- tb/rwx_host_model.sv
`timescale 1ns/1ps
// ==================================================
// Host side: step trigger pin and readback clock
module rwx_host_model (
  input  wire logic pclk,              // Clock
  input  wire logic status_output_pin, // Readback bit
  output logic      step_trigger,      // Step and interrupt pin
  output logic      readback_clk       // Serial clock, idle low
);
  // Serial clock stands low outside frames
  initial
  begin
    step_trigger = 1'b0;
    readback_clk = 1'b0;
  end
  // Held two cycles so the synchroniser cannot miss it
  task automatic pulse_trig();
    @(posedge pclk);
    step_trigger <= 1'b1;
    repeat (2) @(posedge pclk);
    step_trigger <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // MSB stands before the first rise; later bits read after each fall
  task automatic read_word(output logic [36:0] w);
    w[36] = status_output_pin;
    for (int i = 35; i >= 0; i--)
    begin
      @(posedge pclk);
      readback_clk <= 1'b1;
      repeat (3) @(posedge pclk);
      readback_clk <= 1'b0;
      repeat (3) @(posedge pclk);
      #1 w[i] = status_output_pin;
    end
  endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
// ==================================================
// Bench: bus tasks, host model, scenario sequence
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        step_trigger, readback_clk, status_output_pin, fast_lock_out, ramp_active;
  logic [11:0] n_int_out;
  logic [24:0] n_frac_out;
  logic [24:0] f [4];
  logic [36:0] w;
  int          n_fail, num_checks, nhi, nfl, t0, t;
  int          dly [3] = '{0, 19, 59};
  logic [31:0] r7 [3] = '{32'h0000_8008, 32'h0000_80a0, 32'h0001_80a0};
  logic [1:0]  im [4] = '{2'h1, 2'h0, 2'h1, 2'h3};
  rwx_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_trigger(step_trigger), .readback_clk(readback_clk),
    .status_output_pin(status_output_pin), .fast_lock_out(fast_lock_out),
    .ramp_active(ramp_active), .n_int_out(n_int_out), .n_frac_out(n_frac_out)
  );
  rwx_host_model i_host (
    .pclk(pclk), .status_output_pin(status_output_pin),
    .step_trigger(step_trigger), .readback_clk(readback_clk)
  );
  // ==================================================
  // Clock, watchdog and pin counters
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #500000;
    n_fail++;
    test_done();
  end
  always @(posedge pclk)
  begin
    if (status_output_pin === 1'b1)
      nhi++;
    if (fast_lock_out === 1'b1)
      nfl++;
  end
  // ==================================================
  // Tasks
  task automatic check(string nm, logic [36:0] seen, logic [36:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until ready is sampled high
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Cycles from a ramp start until the first hop lands
  task automatic meas(output int n);
    apb(1'b1, 8'h00, 32'h8008_0000);
    n = 0;
    while (n_frac_out === 25'h0 && n < 900)
    begin
      @(posedge pclk);
      n++;
    end
    apb(1'b1, 8'h00, 32'h0008_0000);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==================================================
  // Scenarios
  initial
  begin
    n_fail = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Word storage, then a refused address
    apb(1'b1, 8'h1c, 32'h0007_fff8);
    apb(1'b0, 8'h1c, 32'h0);
    check("r7", rd, 32'h0007_fff8);
    apb(1'b0, 8'h2c, 32'h0);
    check("unmapped", {er, rd}, 33'h1_0000_0000);
    // Start delay; relative timing hides fixed pipeline latency
    apb(1'b1, 8'h08, 32'h0000_0018);
    apb(1'b1, 8'h10, 32'h0000_0080);
    apb(1'b1, 8'h14, 32'h0000_0008);
    apb(1'b1, 8'h18, 32'h0000_0040);
    apb(1'b1, 8'h0c, 32'h0000_0000);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 8'h1c, r7[i]);
      meas(t);
      if (i == 0)
        t0 = t;
      check("start delay", t - t0, dly[i]);
    end
    // External steps, shifted hop, complete pulse
    apb(1'b1, 8'h1c, 32'h0);
    apb(1'b1, 8'h14, 32'h2010_0008);
    apb(1'b1, 8'h18, 32'h0000_0018);
    apb(1'b1, 8'h10, 32'h0060_0080);
    apb(1'b1, 8'h00, 32'hf808_0000);
    nhi = 0;
    repeat (20) @(posedge pclk);
    check("no timer hop", n_frac_out, 25'h0);
    check("int part", n_int_out, 12'h010);
    check("active", ramp_active, 1'b1);
    for (int i = 1; i <= 3; i++)
    begin
      i_host.pulse_trig();
      repeat (4) @(posedge pclk);
      check("ext hop", n_frac_out, 25'(4 * i));
    end
    repeat (10) @(posedge pclk);
    check("done pulses", nhi, 1);
    // Parabola: each hop one word larger than the last
    apb(1'b1, 8'h14, 32'h3000_0008);
    apb(1'b1, 8'h18, 32'h0000_0040);
    apb(1'b1, 8'h0c, 32'h0000_0c08);
    apb(1'b1, 8'h0c, 32'h0000_0c00);
    apb(1'b1, 8'h00, 32'h8008_0000);
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 4; i++)
    begin
      f[i] = n_frac_out;
      i_host.pulse_trig();
      repeat (4) @(posedge pclk);
    end
    check("parabola", (f[3] - f[2]) - (f[2] - f[1]), 37'h1);
    // Readback per interrupt mode; slow timer keeps n at base
    apb(1'b1, 8'h08, 32'h0000_7ff8);
    apb(1'b1, 8'h10, 32'h0047_ff80);
    apb(1'b1, 8'h04, 32'h055e_0000);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'h14, {4'h0, im[i], 26'h8});
      apb(1'b1, 8'h00, i == 0 ? 32'h7891_a2b0 : 32'hf891_a2b0);
      repeat (5) @(posedge pclk);
      i_host.pulse_trig();
      repeat (5) @(posedge pclk);
      i_host.read_word(w);
      check("readback", w, i < 2 ? 37'h0 : {12'h123, 12'h456, 13'h0abc});
    end
    // Fast-lock window only outside ramp mode
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h08, 32'h0000_0018);
    apb(1'b1, 8'h10, 32'h0008_0280);
    nfl = 0;
    apb(1'b1, 8'h00, 32'h0);
    repeat (40) @(posedge pclk);
    check("lock window", nfl, 15);
    nfl = 0;
    apb(1'b1, 8'h00, 32'h8000_0000);
    repeat (40) @(posedge pclk);
    check("lock in ramp", nfl, 0);
    // Fast triangle: up two hops of 1, down one hop of 2; base fraction 0abc
    apb(1'b1, 8'h1c, 32'h0008_0000);
    apb(1'b1, 8'h0c, 32'h0000_0400);
    apb(1'b1, 8'h14, 32'h2000_0008);
    apb(1'b1, 8'h18, 32'h0000_0010);
    apb(1'b1, 8'h14, 32'h2080_0010);
    apb(1'b1, 8'h18, 32'h0080_0008);
    apb(1'b1, 8'h00, 32'h8008_0000);
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 4; i++)
    begin
      i_host.pulse_trig();
      f[i] = n_frac_out;
    end
    check("up slope", f[1], 25'h0abe);
    check("down slope", f[3], 25'h0abc);
    test_done();
  end
endmodule
